// [rtl/swing_seq.sv]
// Power swing blocking and out-of-step trip sequencer with APB registers
// Operation
// - Blocking needs locus in outer, outside inner/middle, for pickup delay 1.
// - Pickup delay 1 completion sets the block latch driving block output.
// - Leaving outer starts reset delay 1; latch clears at its expiry.
// - The same first-stage qualification starts the trip sequence.
// - Three-step only: between middle and inner for pickup delay 2.
// - Inside inner for pickup delay 3 arms the trip.
// - Delayed mode: outside inner, inside outer, for pickup delay 4.
// - Delayed mode: trip when locus leaves outer once ready.
// - Trip output held for the seal-in period after each trip.
// - Early mode: trip immediately when the final stage completes.
// - Trip inhibit affects trip only; blocking keeps working.
// - Inhibit forces trip low but sequence keeps advancing.
// - Two-step skips delay 2; first stage uses outer and inner.
// - Trip sequence latches clear whenever locus exits outer.
// - Delays programmable 0 to 65.535 s in 1 ms steps.
// - Function disable clears and holds block and trip outputs inactive; irq still follows the sticky events.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module swing_seq
  import swing_seq_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Region flags, asynchronous to this clock
  input wire swing_seq_pkg::zone_s zone_in,
  // Trip inhibit, asynchronous
  input wire logic trip_inhibit_input,
  // Element outputs
  output logic swing_block,
  output logic oos_trip,
  output logic irq
);
  import swing_seq_pkg::*;

  // Input synchronisers: first stage feeds only the second
  zone_s zone_m_r, zone_r;
  logic inh_m_r, inh_r;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      zone_m_r <= '0;
      zone_r <= '0;
      inh_m_r <= 1'b0;
      inh_r <= 1'b0;
    end
    else
    begin
      zone_m_r <= zone_in;
      zone_r <= zone_m_r;
      inh_m_r <= trip_inhibit_input;
      inh_r <= inh_m_r;
    end
  end

  // Registers
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [DLY_W-1:0] pkp_r [4];
  logic [DLY_W-1:0] pkp_nxt [4];
  logic [DLY_W-1:0] rst1_r, rst1_nxt, hold_r, hold_nxt;
  logic [EV_W-1:0] ev_r, ev_nxt, mask_r, mask_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [EV_W-1:0] ev_set;
  logic wr, rd;
  assign wr = psel && penable && pwrite && !pready;
  assign rd = psel && penable && !pwrite && !pready;

  // Register writes, reads and sticky events; set wins over clear-on-read
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    pkp_nxt = pkp_r;
    rst1_nxt = rst1_r;
    hold_nxt = hold_r;
    mask_nxt = mask_r;
    ev_nxt = ev_r;
    prdata_nxt = prdata;
    pready_nxt = psel && penable && !pready;
    pslverr_nxt = 1'b0;
    if (wr || rd)
    begin
      pslverr_nxt = 1'b0;
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        ADDR_CTRL: begin if (wr) ctrl_nxt = pwdata[2:0]; prdata_nxt[2:0] = ctrl_r; end
        ADDR_PKP1: begin if (wr) pkp_nxt[0] = pwdata[15:0]; prdata_nxt[15:0] = pkp_r[0]; end
        ADDR_PKP2: begin if (wr) pkp_nxt[1] = pwdata[15:0]; prdata_nxt[15:0] = pkp_r[1]; end
        ADDR_PKP3: begin if (wr) pkp_nxt[2] = pwdata[15:0]; prdata_nxt[15:0] = pkp_r[2]; end
        ADDR_PKP4: begin if (wr) pkp_nxt[3] = pwdata[15:0]; prdata_nxt[15:0] = pkp_r[3]; end
        ADDR_RST1: begin if (wr) rst1_nxt = pwdata[15:0]; prdata_nxt[15:0] = rst1_r; end
        ADDR_HOLD: begin if (wr) hold_nxt = pwdata[15:0]; prdata_nxt[15:0] = hold_r; end
        ADDR_STAT: prdata_nxt[1:0] = {oos_trip, swing_block};
        ADDR_IRQ: begin prdata_nxt[EV_W-1:0] = ev_r; if (rd) ev_nxt = '0; end
        ADDR_MASK: begin if (wr) mask_nxt = pwdata[EV_W-1:0]; prdata_nxt[EV_W-1:0] = mask_r; end
        default: pslverr_nxt = 1'b1;
      endcase
    end
    ev_nxt = ev_nxt | ev_set;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_r <= CTRL_RST;
      for (int i = 0; i < 4; i++) pkp_r[i] <= PKP_RST;
      rst1_r <= PKP_RST;
      hold_r <= HOLD_RST;
      mask_r <= '0;
      ev_r <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      pkp_r <= pkp_nxt;
      rst1_r <= rst1_nxt;
      hold_r <= hold_nxt;
      mask_r <= mask_nxt;
      ev_r <= ev_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // Millisecond tick
  logic [31:0] div_r, div_nxt;
  logic tick;
  assign tick = (div_r == 32'(TICK_DIV - 1));
  always_comb
  begin
    div_nxt = tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
  end

  // Element qualification terms
  logic en, three, delayed, in_o, in_m, in_i, reg1;
  assign en = ctrl_r[CTRL_EN];
  assign three = ctrl_r[CTRL_THREE];
  assign delayed = ctrl_r[CTRL_DELAYED];
  assign in_o = zone_r.outer;
  assign in_m = zone_r.middle;
  assign in_i = zone_r.inner;
  assign reg1 = in_o && (three ? !in_m : !in_i);

  // Timers: pickup 1..4, reset delay 1 and seal-in, counting ms ticks
  seq_e st_r, st_nxt;
  logic blk_r, blk_nxt, seal_r, seal_nxt, trip_nxt, trip_ev;
  logic [DLY_W:0] t_r [6];
  logic [DLY_W:0] t_nxt [6];
  logic [5:0] t_run;
  logic [DLY_W-1:0] t_lim [6];
  logic [5:0] t_done;
  assign t_lim[0] = pkp_r[0];
  assign t_lim[1] = pkp_r[1];
  assign t_lim[2] = pkp_r[2];
  assign t_lim[3] = pkp_r[3];
  assign t_lim[4] = rst1_r;
  assign t_lim[5] = hold_r;
  // Qualifying conditions per timer
  assign t_run[0] = en && reg1;
  assign t_run[1] = en && st_r == ST_S1 && in_m && !in_i;
  assign t_run[2] = en && (st_r == ST_S2 || (st_r == ST_S1 && !three)) && in_i;
  assign t_run[3] = en && st_r == ST_ARMED && delayed && in_o && !in_i;
  assign t_run[4] = en && blk_r && !in_o;
  // Seal-in counts only while its flag is set, so a trip between ticks still holds
  assign t_run[5] = en && seal_r;

  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_tmr
      assign t_done[g] = t_run[g] && (t_r[g][DLY_W-1:0] >= t_lim[g]);
      always_comb
      begin
        if (!t_run[g] || (g == 5 && trip_ev))
          t_nxt[g] = '0;
        else if (tick && !t_done[g])
          t_nxt[g] = t_r[g] + 17'h00001;
        else
          t_nxt[g] = t_r[g];
      end
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
          t_r[g] <= '0;
        else
          t_r[g] <= t_nxt[g];
      end
    end
  endgenerate

  // Blocking latch and trip sequence
  always_comb
  begin
    blk_nxt = blk_r;
    st_nxt = st_r;
    trip_ev = 1'b0;
    // blocking after pickup delay 1 in region
    if (t_done[0])
      blk_nxt = 1'b1;
    // clear when reset delay 1 expires or when the function is disabled
    if (t_done[4])
      blk_nxt = 1'b0;
    case (st_r)
      ST_IDLE: if (t_done[0]) st_nxt = ST_S1;
      ST_S1:
      begin
        if (three && t_done[1])
          st_nxt = ST_S2;
        // two-step goes straight to inner timing
        else if (!three && t_done[2])
          st_nxt = ST_ARMED;
      end
      ST_S2: if (t_done[2]) st_nxt = ST_ARMED;
      ST_ARMED:
      begin
        if (!delayed)
        begin
          trip_ev = 1'b1;
          st_nxt = ST_IDLE;
        end
        // delayed mode needs pickup delay 4
        else if (t_done[3])
          st_nxt = ST_READY;
      end
      ST_READY:
      begin
        if (!in_o)
        begin
          trip_ev = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (!in_o && st_r != ST_READY)
      st_nxt = ST_IDLE;
    if (!en)
    begin
      blk_nxt = 1'b0;
      st_nxt = ST_IDLE;
      trip_ev = 1'b0;
    end
    // seal-in holds trip; inhibit masks output only
    seal_nxt = en && (trip_ev || (seal_r && !t_done[5]));
    trip_nxt = en && !inh_r && (trip_ev || (seal_r && !t_done[5]));
  end

  assign ev_set = {trip_ev, st_nxt == ST_ARMED && st_r != ST_ARMED, blk_nxt && !blk_r};

  // reset clears timers, latches and outputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_r <= 32'h0000_0000;
      st_r <= ST_IDLE;
      blk_r <= 1'b0;
      seal_r <= 1'b0;
      swing_block <= 1'b0;
      oos_trip <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      st_r <= st_nxt;
      blk_r <= blk_nxt;
      seal_r <= seal_nxt;
      swing_block <= blk_nxt;
      oos_trip <= trip_nxt;
      irq <= |(ev_nxt & mask_r);
    end
  end
endmodule : swing_seq
`default_nettype wire

// [rtl/swing_seq_pkg.sv]
// Package: constants, types and register map for the power swing sequencer
package swing_seq_pkg;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DLY_W = 16;
  localparam int DLY_MAX_MS = 65535;
  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PKP1 = 8'h04;
  localparam logic [7:0] ADDR_PKP2 = 8'h08;
  localparam logic [7:0] ADDR_PKP3 = 8'h0C;
  localparam logic [7:0] ADDR_PKP4 = 8'h10;
  localparam logic [7:0] ADDR_RST1 = 8'h14;
  localparam logic [7:0] ADDR_HOLD = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1C;
  localparam logic [7:0] ADDR_IRQ = 8'h20;
  localparam logic [7:0] ADDR_MASK = 8'h24;
  // Control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_THREE = 1;
  localparam int CTRL_DELAYED = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // Delay reset values in ms
  localparam logic [15:0] PKP_RST = 16'h0000;
  localparam logic [15:0] HOLD_RST = 16'h0000;
  // Interrupt event bits
  localparam int EV_BLOCK = 0;
  localparam int EV_ARM = 1;
  localparam int EV_TRIP = 2;
  localparam int EV_W = 3;
  // Region flags from the impedance comparators
  typedef struct packed {
    logic outer;
    logic middle;
    logic inner;
  } zone_s;
  // Trip sequence states
  typedef enum logic [2:0] {ST_IDLE, ST_S1, ST_S2, ST_ARMED, ST_READY} seq_e;
endpackage : swing_seq_pkg

// [test/swing_seq_props.sv]
// Checker: bus handshake, reset and trip output relations of the sequencer
`timescale 1ns/10ps
`default_nettype none
module swing_seq_props
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Element pins
  input wire logic trip_inhibit_input,
  input wire logic swing_block,
  input wire logic oos_trip,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Bus answers once, one cycle after the first access edge
  a_pready_resp: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_idle_bus: assert property (!psel |=> !pready)
    else $error("pready without transfer");
  a_slverr_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read data not zero");
  // Inhibit holds the trip low after its sync lag
  a_inh_trip_low: assert property (trip_inhibit_input [*5] |-> !oos_trip)
    else $error("trip high while inhibited");
  // Three samples back: two sync flops plus the output register
  a_inh_no_rise: assert property ($rose(oos_trip) |-> !$past(trip_inhibit_input, 3))
    else $error("trip rose under inhibit");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !swing_block && !oos_trip && !irq)
    else $error("outputs active after reset");
  // Main scenarios
  cover property ($rose(swing_block));
  cover property ($rose(oos_trip));
  cover property (pready && pslverr);
endmodule : swing_seq_props
`default_nettype wire

// [test/tb_swing_seq.sv]
// Testbench: register access and swing blocking / trip sequences
`timescale 1ns/10ps
`default_nettype none
module tb_swing_seq;
  import swing_seq_pkg::*;
  logic clk = 0;
  logic sys_rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic trip_inhibit_input = 0;
  logic [1:0] region = 2'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, swing_block, oos_trip, irq, e;
  zone_s zone_in;
  int n_fail = 0;
  int compares = 0;

  // 40 MHz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // Short tick so a millisecond is ten cycles
  swing_seq #(.TICK_DIV(10)) DUT
  (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zone_in(zone_in), .trip_inhibit_input(trip_inhibit_input),
    .swing_block(swing_block), .oos_trip(oos_trip), .irq(irq)
  );
  zone_model u_zone (.clk(clk), .region(region), .zone(zone_in));

  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  task automatic wt(input int ms);
    repeat (ms * 10) @(posedge clk);
  endtask : wt

  // One APB transfer; the wait is bounded so a dead slave cannot hang us
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk("pready", {31'h0, pready}, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk("prdata", q, exp);
  endtask : rd

  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // Watchdog far beyond the expected run of about five hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  // Test sequence
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    rd(ADDR_CTRL, 32'h0);
    xfer(1'b1, ADDR_PKP1, 32'hFFFF_0002);
    rd(ADDR_PKP1, 32'h2);
    rd(8'hFC, 32'h0);
    chk("pslverr", {31'h0, e}, 32'h1);
    xfer(1'b1, ADDR_PKP2, 32'h2);
    xfer(1'b1, ADDR_PKP3, 32'h2);
    xfer(1'b1, ADDR_PKP4, 32'h2);
    xfer(1'b1, ADDR_RST1, 32'h3);
    xfer(1'b1, ADDR_HOLD, 32'h4);
    xfer(1'b1, ADDR_MASK, 32'h7);
    xfer(1'b1, ADDR_CTRL, 32'h3);
    $display("test regs done");
    // Three-step, early trip
    region <= 2'h1;
    wt(1);
    chk("block", swing_block, 0);
    wt(3);
    chk("block", swing_block, 1);
    region <= 2'h2;
    wt(4);
    region <= 2'h3;
    wt(1);
    chk("trip", oos_trip, 0);
    wt(3);
    chk("trip", oos_trip, 1);
    region <= 2'h0;
    wt(1);
    chk("trip", oos_trip, 1);
    chk("block", swing_block, 1);
    wt(4);
    chk("trip", oos_trip, 0);
    chk("block", swing_block, 0);
    chk("irq", irq, 1);
    rd(ADDR_IRQ, 32'h7);
    wt(1);
    chk("irq", irq, 0);
    $display("test early done");
    // Two-step, delayed trip, inhibited while the sequence advances
    xfer(1'b1, ADDR_CTRL, 32'h5);
    trip_inhibit_input <= 1;
    region <= 2'h2;
    wt(4);
    chk("block", swing_block, 1);
    region <= 2'h3;
    wt(4);
    chk("trip", oos_trip, 0);
    region <= 2'h2;
    wt(4);
    chk("trip", oos_trip, 0);
    // Exit while inhibited: trip masked, seal-in still runs
    region <= 2'h0;
    wt(1);
    chk("trip", oos_trip, 0);
    trip_inhibit_input <= 0;
    wt(1);
    chk("trip", oos_trip, 1);
    xfer(1'b1, ADDR_CTRL, 32'h0);
    wt(1);
    chk("trip", oos_trip, 0);
    chk("block", swing_block, 0);
    rd(ADDR_IRQ, 32'h7);
    $display("test delayed done");
    // Interrupted qualification restarts; masked event keeps irq low
    xfer(1'b1, ADDR_MASK, 32'h0);
    xfer(1'b1, ADDR_CTRL, 32'h1);
    region <= 2'h1;
    wt(1);
    region <= 2'h0;
    wt(1);
    region <= 2'h1;
    wt(1);
    // Past the point where a kept count would already have completed
    repeat (6) @(posedge clk);
    chk("block", swing_block, 0);
    wt(3);
    chk("block", swing_block, 1);
    chk("irq", irq, 0);
    rd(ADDR_IRQ, 32'h1);
    $display("test restart done");
    print_verdict();
  end
endmodule : tb_swing_seq

bind swing_seq swing_seq_props u_props
(
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .trip_inhibit_input(trip_inhibit_input), .swing_block(swing_block),
  .oos_trip(oos_trip), .irq(irq)
);
`default_nettype wire

// [test/zone_model.sv]
// Model of the impedance comparators driving nested region flags
`timescale 1ns/10ps
`default_nettype none
module zone_model
  import swing_seq_pkg::*;
(
  // Clock
  input wire logic clk,
  // Commanded region: 0 out, 1 outer, 2 middle, 3 inner
  input wire logic [1:0] region,
  // Flags to the sequencer
  output var swing_seq_pkg::zone_s zone
);
  // Boundaries nest, so inner implies middle implies outer
  always_ff @(posedge clk)
  begin
    zone.outer <= region != 2'h0;
    zone.middle <= region[1];
    zone.inner <= region == 2'h3;
  end
endmodule : zone_model
`default_nettype wire
